// ---- src/tfl_fault_top.sv ----
// Purpose: thermistor and undervoltage fault logic with AXI4-Lite registers
// Assumes: comparator flags come asynchronously from the analog front end
// Notes: all fault timers count the common timebase tick
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tfl_fault_top #(
  parameter int TICK_CYC = tfl_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [tfl_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [tfl_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // comparator flags from the analog front end
  input wire logic sense_above_ext_bias,
  input wire logic sense_below_hot,
  input wire logic sense_open_or_cold,
  input wire logic sense_shorted,
  input wire logic cell_below_uv,
  input wire logic cells_above_uv_hyst,
  input wire logic load_removed,
  input wire logic charger_sense,
  input wire logic regulator_ready,
  input wire logic overvolt_fault,
  // pin controls
  output logic charge_gate,
  output logic discharge_gate,
  output logic thermistor_bias_out,
  output logic thermistor_pulldown_oe,
  output logic regulator_en
);
  tfl_tb_if tb ();

  tfl_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
    .mclk(mclk),
    .nrst(nrst),
    .tb(tb)
  );

  // register decode shared by read and write paths
  function automatic logic [2:0] f_dec(
    input logic [tfl_pkg::AXI_AW-1:0] addr
  );
    logic [1:0] idx;
    idx = addr[3:2];
    f_dec = {idx <= tfl_pkg::IDX_STAT, idx};
  endfunction : f_dec

  // flag synchroniser: stage one feeds stage two only
  logic [tfl_pkg::NFLAG-1:0] raw_flags;
  logic [tfl_pkg::NFLAG-1:0] sync1_q, sync2_q, flag_q;
  assign raw_flags = {regulator_ready, charger_sense, load_removed,
                      cells_above_uv_hyst, cell_below_uv, sense_shorted,
                      sense_open_or_cold, sense_below_hot,
                      sense_above_ext_bias};

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      flag_q <= '0;
    end else begin
      sync1_q <= raw_flags;
      sync2_q <= sync1_q;
      flag_q <= sync2_q;
    end
  end

  logic ovf_s1_q, ovf_s2_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ovf_s1_q <= 1'b0;
      ovf_s2_q <= 1'b0;
    end else begin
      ovf_s1_q <= overvolt_fault;
      ovf_s2_q <= ovf_s1_q;
    end
  end

  // axi4-lite slave
  logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d;
  logic [tfl_pkg::AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [tfl_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [tfl_pkg::CNT_W-1:0] uvdly_q, uvdly_d;
  logic [tfl_pkg::STAT_W-1:0] status;
  logic [2:0] wdec, rdec;

  assign s_axi_awready = !aw_ok_q && !bvalid_q;
  assign s_axi_wready = !w_ok_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  always_comb begin
    aw_ok_d = aw_ok_q;
    w_ok_d = w_ok_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    uvdly_d = uvdly_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    wdec = f_dec(awaddr_d);
    if (aw_ok_d && w_ok_d && !bvalid_q) begin
      aw_ok_d = 1'b0;
      w_ok_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wdec[2] ? tfl_pkg::RESP_OKAY : tfl_pkg::RESP_SLVERR;
      if (wdec == {1'b1, tfl_pkg::IDX_CTRL} && wstrb_d[0]) begin
        ctrl_d = wdata_d[tfl_pkg::CTRL_W-1:0];
      end
      if (wdec == {1'b1, tfl_pkg::IDX_UVDLY}) begin
        if (wstrb_d[0]) begin
          uvdly_d[7:0] = wdata_d[7:0];
        end
        if (wstrb_d[1]) begin
          uvdly_d[15:8] = wdata_d[15:8];
        end
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    rdec = f_dec(s_axi_araddr);
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = rdec[2] ? tfl_pkg::RESP_OKAY : tfl_pkg::RESP_SLVERR;
      case (rdec)
        {1'b1, tfl_pkg::IDX_CTRL}: rdata_d = 32'(ctrl_q);
        {1'b1, tfl_pkg::IDX_UVDLY}: rdata_d = 32'(uvdly_q);
        {1'b1, tfl_pkg::IDX_STAT}: rdata_d = 32'(status);
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= tfl_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= tfl_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      ctrl_q <= tfl_pkg::CTRL_RST;
      uvdly_q <= tfl_pkg::UVDLY_RST;
    end else begin
      aw_ok_q <= aw_ok_d;
      w_ok_q <= w_ok_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      uvdly_q <= uvdly_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // fault state
  tfl_pkg::tfl_state_e st_q, st_d;
  logic hot_q, hot_d, open_q, open_d, short_q, short_d;
  logic uvf_q, uvf_d, cgate_q, cgate_d, dgate_q, dgate_d;
  logic bias_q, bias_d, pd_q, pd_d, reg_q, reg_d, chpres_q, chpres_d;
  logic [tfl_pkg::CNT_W-1:0] uv_cnt_q, uv_cnt_d, sd_cnt_q, sd_cnt_d;
  logic tick, sample, ext_bias, recover;

  assign tick = tb.tick;
  assign ext_bias = flag_q[tfl_pkg::FL_EXT];
  // no temperature sample while our own pulldown forces the line to ground
  assign sample = tick && tb.check_slot && !pd_q &&
                  !ctrl_q[tfl_pkg::CB_TDIS] && st_q == tfl_pkg::ST_ACTIVE;
  assign recover = flag_q[tfl_pkg::FL_UVOK] &&
                   (!ctrl_q[tfl_pkg::CB_UVREC] ||
                    flag_q[tfl_pkg::FL_LOADOFF]);
  assign status = {dgate_q, cgate_q, ext_bias, chpres_q, pd_q,
                   st_q == tfl_pkg::ST_SHUT, uvf_q, short_q, open_q, hot_q};

  always_comb begin
    st_d = st_q;
    hot_d = hot_q;
    open_d = open_q;
    short_d = short_q;
    uvf_d = uvf_q;
    uv_cnt_d = uv_cnt_q;
    sd_cnt_d = sd_cnt_q;
    chpres_d = chpres_q;
    // sense pulled low only with the signalling bit, monitor bit ignored
    pd_d = ctrl_q[tfl_pkg::CB_OVTS] && ovf_s2_q &&
           !tb.release_win;
    if (!pd_q) begin
      chpres_d = flag_q[tfl_pkg::FL_CHARGER];
    end
    if (sample) begin
      hot_d = flag_q[tfl_pkg::FL_HOT];
      open_d = flag_q[tfl_pkg::FL_OPEN];
      short_d = flag_q[tfl_pkg::FL_SHORT];
    end
    if (!flag_q[tfl_pkg::FL_UV]) begin
      uv_cnt_d = '0;
    end else if (tick && uv_cnt_q != tfl_pkg::CNT_MAX) begin
      uv_cnt_d = uv_cnt_q + 16'h0001;
    end
    if (uv_cnt_q > uvdly_q) begin
      uvf_d = 1'b1;
    end else if (uvf_q && recover) begin
      uvf_d = 1'b0;
    end
    if (!uvf_q || flag_q[tfl_pkg::FL_UVOK]) begin
      sd_cnt_d = '0;
    end else if (tick && sd_cnt_q != tfl_pkg::CNT_MAX) begin
      sd_cnt_d = sd_cnt_q + 16'h0001;
    end
    case (st_q)
      tfl_pkg::ST_PWRUP: begin
        if (flag_q[tfl_pkg::FL_REGOK]) begin
          st_d = tfl_pkg::ST_ACTIVE;
        end
      end
      tfl_pkg::ST_ACTIVE: begin
        if (sample && flag_q[tfl_pkg::FL_SHORT]) begin
          st_d = tfl_pkg::ST_SHUT;
        end
        if (ctrl_q[tfl_pkg::CB_UVSD] &&
            sd_cnt_q > tfl_pkg::UV_SD_TICKS) begin
          st_d = tfl_pkg::ST_SHUT;
        end
      end
      tfl_pkg::ST_SHUT: begin
        // a sense already high on entry counts as insertion at once, no edge is needed
        if (chpres_q && !pd_q) begin
          st_d = tfl_pkg::ST_PWRUP;
          short_d = 1'b0;
          uvf_d = 1'b0;
          open_d = 1'b0;
          hot_d = 1'b0;
        end
      end
      default: st_d = tfl_pkg::ST_PWRUP;
    endcase
    reg_d = st_d != tfl_pkg::ST_SHUT || ctrl_q[tfl_pkg::CB_KEEP];
    cgate_d = reg_d && st_d == tfl_pkg::ST_ACTIVE &&
              !hot_d && !open_d && !short_d && !uvf_d;
    dgate_d = cgate_d;
    bias_d = tb.check_slot && !ext_bias && !pd_d &&
             !ctrl_q[tfl_pkg::CB_TDIS] &&
             st_d == tfl_pkg::ST_ACTIVE;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_q <= tfl_pkg::ST_PWRUP;
      hot_q <= 1'b0;
      open_q <= 1'b0;
      short_q <= 1'b0;
      uvf_q <= 1'b0;
      uv_cnt_q <= '0;
      sd_cnt_q <= '0;
      chpres_q <= 1'b0;
      pd_q <= 1'b0;
      reg_q <= 1'b1;
      cgate_q <= 1'b0;
      dgate_q <= 1'b0;
      bias_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hot_q <= hot_d;
      open_q <= open_d;
      short_q <= short_d;
      uvf_q <= uvf_d;
      uv_cnt_q <= uv_cnt_d;
      sd_cnt_q <= sd_cnt_d;
      chpres_q <= chpres_d;
      pd_q <= pd_d;
      reg_q <= reg_d;
      cgate_q <= cgate_d;
      dgate_q <= dgate_d;
      bias_q <= bias_d;
    end
  end

  assign charge_gate = cgate_q;
  assign discharge_gate = dgate_q;
  assign thermistor_bias_out = bias_q;
  assign thermistor_pulldown_oe = pd_q;
  assign regulator_en = reg_q;
endmodule : tfl_fault_top

// ---- src/tfl_pkg.sv ----
// Purpose: constants and types of the thermistor and undervoltage fault logic
// Assumes: 25 MHz clock, common 10 ms timebase tick
// Notes: all tick counts except the UVDLY_RST reset value derive from times in milliseconds
package tfl_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int REL_MS = 200;
  localparam int PERIOD_MS = 4000;
  localparam int UV_SD_MS = 8000;
  localparam int CHECK_MS = 250;
  localparam int SLOT_W = 9;
  localparam int CNT_W = 16;
  localparam logic [SLOT_W-1:0] REL_TICKS = SLOT_W'(REL_MS / TICK_MS);
  localparam logic [SLOT_W-1:0] PERIOD_TICKS = SLOT_W'(PERIOD_MS / TICK_MS);
  localparam logic [SLOT_W-1:0] CHECK_TICKS = SLOT_W'(CHECK_MS / TICK_MS);
  localparam logic [CNT_W-1:0] UV_SD_TICKS = CNT_W'(UV_SD_MS / TICK_MS);
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  // register map, word indexes decoded from address bits 3:2
  localparam int AXI_AW = 4;
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_UVDLY = 2'h1;
  localparam logic [1:0] IDX_STAT = 2'h2;
  localparam int CTRL_W = 5;
  localparam int CB_OVTS = 0;
  localparam int CB_TDIS = 1;
  localparam int CB_UVREC = 2;
  localparam int CB_UVSD = 3;
  localparam int CB_KEEP = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [CNT_W-1:0] UVDLY_RST = 16'h0032;
  localparam int STAT_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // synchronised input flags
  localparam int NFLAG = 9;
  localparam int FL_EXT = 0;
  localparam int FL_HOT = 1;
  localparam int FL_OPEN = 2;
  localparam int FL_SHORT = 3;
  localparam int FL_UV = 4;
  localparam int FL_UVOK = 5;
  localparam int FL_LOADOFF = 6;
  localparam int FL_CHARGER = 7;
  localparam int FL_REGOK = 8;
  typedef enum logic [1:0] {ST_PWRUP, ST_ACTIVE, ST_SHUT} tfl_state_e;
endpackage : tfl_pkg

// ---- src/tfl_tb_if.sv ----
// Purpose: timebase signals from the divider to the fault logic
// Assumes: single mclk domain
// Notes: tick is a one-cycle enable
`timescale 1ns/1ps
interface tfl_tb_if;
  logic tick;
  logic release_win;
  logic check_slot;
  modport src (output tick, output release_win, output check_slot);
  modport dst (input tick, input release_win, input check_slot);
endinterface : tfl_tb_if

// ---- src/tfl_timebase.sv ----
// Purpose: common low-rate tick and the 4 s sampling frame
// Assumes: synchronous active-low reset
// Notes: release window is the first 200 ms of each 4 s frame
`timescale 1ns/1ps
module tfl_timebase #(
  parameter int TICK_CYC = tfl_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // timebase out
  tfl_tb_if.src tb
);
  localparam logic [17:0] DIV_LAST = 18'(TICK_CYC - 1);
  logic [17:0] div_q, div_d;
  logic [tfl_pkg::SLOT_W-1:0] slot_q, slot_d;
  logic tick_q, tick_d;

  always_comb begin
    div_d = div_q + 18'h00001;
    slot_d = slot_q;
    tick_d = 1'b0;
    if (div_q == DIV_LAST) begin
      div_d = 18'h00000;
      tick_d = 1'b1;
      slot_d = slot_q + 9'h001;
      if (slot_q == tfl_pkg::PERIOD_TICKS - 9'h001) begin
        slot_d = 9'h000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_q <= 18'h00000;
      slot_q <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      slot_q <= slot_d;
      tick_q <= tick_d;
    end
  end

  assign tb.tick = tick_q;
  assign tb.release_win = slot_q < tfl_pkg::REL_TICKS;
  assign tb.check_slot = (slot_q % tfl_pkg::CHECK_TICKS) == 9'h000;
endmodule : tfl_timebase

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the fault logic
// Assumes: TICK_CYC shortened to 20 cycles
// Notes: waits are counted in timebase ticks
`timescale 1ns/1ps
module tb;
  localparam int TCK = 20;
  logic mclk = 1'h0, nrst = 1'h0, plugged = 1'h0, regulator_ready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, v;
  logic [31:0] sh_ctrl = 32'h0, sh_dly = 32'h32;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, overvolt_fault = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sense_above_ext_bias, charger_sense, charge_gate;
  logic discharge_gate, thermistor_bias_out, thermistor_pulldown_oe;
  logic regulator_en, sense_below_hot = 1'h0, sense_open_or_cold = 1'h0;
  logic sense_shorted = 1'h0, cell_below_uv = 1'h0;
  logic cells_above_uv_hyst = 1'h1, load_removed = 1'h1;
  int n_fail = 0, checks_done = 0, cyc = 0, seed = 81649, n;
  tfl_fault_top #(.TICK_CYC(TCK)) dut_u (.mclk, .nrst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense_above_ext_bias,
    .sense_below_hot, .sense_open_or_cold, .sense_shorted, .cell_below_uv,
    .cells_above_uv_hyst, .load_removed, .charger_sense, .regulator_ready,
    .overvolt_fault, .charge_gate, .discharge_gate, .thermistor_bias_out,
    .thermistor_pulldown_oe, .regulator_en);
  tfl_charger_model partner_u (.plugged,
    .pulldown_oe(thermistor_pulldown_oe), .charger_sense,
    .sense_above_ext_bias);
  always #20 mclk = ~mclk;
  // regulator output settles one cycle after enable
  always @(posedge mclk) regulator_ready <= regulator_en;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask : cmp_pin
  function automatic logic [31:0] exp_rd(input logic [3:0] a);
    if (a[3:2] == tfl_pkg::IDX_CTRL) return sh_ctrl & 32'h1F;
    if (a[3:2] == tfl_pkg::IDX_UVDLY) return sh_dly & 32'hFFFF;
    return 32'h0;
  endfunction : exp_rd
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (!aw && s_axi_awready === 1'h1) begin
        aw = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1) begin
        w = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge mclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axi_rd
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    cmp_reg(rs, tfl_pkg::RESP_OKAY);
    if (a == 4'h0) sh_ctrl = d;
    if (a == 4'h4) sh_dly = d;
  endtask : wreg
  task automatic rchk(input logic [3:0] a);
    axi_rd(a, rd, rs);
    cmp_reg(rs, tfl_pkg::RESP_OKAY);
    cmp_reg(rd, exp_rd(a));
  endtask : rchk
  task automatic wt(input int t);
    repeat (t * TCK) @(posedge mclk);
  endtask : wt
  // pd=1 counts released cycles, pd=0 counts bias-on cycles
  task automatic cnt(input bit pd, input int t, output int c);
    c = 0;
    repeat (t * TCK) begin
      @(posedge mclk);
      if (pd ? thermistor_pulldown_oe !== 1'h1
             : thermistor_bias_out === 1'h1) c++;
    end
  endtask : cnt
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    cmp_pin(charge_gate, 1'h0);
    rchk(4'h0);
    rchk(4'h4);
    axi_rd(4'hC, rd, rs);
    cmp_reg({30'h0, rs}, {30'h0, tfl_pkg::RESP_SLVERR});
    cmp_reg(rd, 32'h0);
    axi_wr(4'hC, 32'hFFFFFFFF, rs);
    cmp_reg({30'h0, rs}, {30'h0, tfl_pkg::RESP_SLVERR});
    axi_wr(4'h8, 32'hFFFFFFFF, rs);
    cmp_reg({30'h0, rs}, {30'h0, tfl_pkg::RESP_OKAY});
    v = $random(seed);
    wreg(4'h4, v);
    rchk(4'h4);
    v = $random(seed);
    wreg(4'h0, v);
    rchk(4'h0);
    wreg(4'h0, 32'h0);
    wt(2);
    cmp_pin(charge_gate, 1'h1);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) sense_below_hot <= 1'h1;
      else sense_open_or_cold <= 1'h1;
      wt(27);
      cmp_pin(discharge_gate, 1'h0);
      cmp_pin(regulator_en, 1'h1);
      axi_rd(4'h8, rd, rs);
      cmp_reg(rd[2:0], (i == 0) ? 32'h1 : 32'h2);
      sense_below_hot <= 1'h0;
      sense_open_or_cold <= 1'h0;
      wt(27);
      cmp_pin(charge_gate, 1'h1);
    end
    plugged <= 1'h1;
    wt(1); // a bias pulse already running ends once ext bias is seen
    cnt(1'b0, 30, n);
    cmp_reg(n, 0);
    axi_rd(4'h8, rd, rs);
    cmp_reg(rd[7:6], 32'h3);
    plugged <= 1'h0;
    cnt(1'b0, 30, n);
    cmp_pin(n > 0, 1'h1);
    wreg(4'h4, 32'h5);
    cell_below_uv <= 1'h1;
    cells_above_uv_hyst <= 1'h0;
    wt(3);
    cmp_pin(discharge_gate, 1'h1);
    wt(6);
    cmp_pin(discharge_gate, 1'h0);
    wt(810);
    cmp_pin(regulator_en, 1'h1);
    cell_below_uv <= 1'h0;
    cells_above_uv_hyst <= 1'h1;
    wt(2);
    cmp_pin(discharge_gate, 1'h1);
    wreg(4'h0, 32'h4);
    load_removed <= 1'h0;
    cell_below_uv <= 1'h1;
    cells_above_uv_hyst <= 1'h0;
    wt(9);
    cell_below_uv <= 1'h0;
    cells_above_uv_hyst <= 1'h1;
    wt(3);
    cmp_pin(discharge_gate, 1'h0);
    load_removed <= 1'h1;
    wt(2);
    cmp_pin(discharge_gate, 1'h1);
    wreg(4'h0, 32'h8);
    cell_below_uv <= 1'h1;
    cells_above_uv_hyst <= 1'h0;
    wt(820);
    cmp_pin(regulator_en, 1'h0);
    cell_below_uv <= 1'h0;
    cells_above_uv_hyst <= 1'h1;
    wt(5);
    cmp_pin(regulator_en, 1'h0);
    plugged <= 1'h1;
    wt(3);
    cmp_pin(charge_gate, 1'h1);
    plugged <= 1'h0;
    wreg(4'h0, 32'h10);
    sense_shorted <= 1'h1;
    wt(27);
    cmp_pin(charge_gate, 1'h0);
    cmp_pin(regulator_en, 1'h1);
    axi_rd(4'h8, rd, rs);
    cmp_pin(rd[4], 1'h1);
    sense_shorted <= 1'h0;
    plugged <= 1'h1;
    wt(3);
    cmp_pin(charge_gate, 1'h1);
    plugged <= 1'h0;
    wreg(4'h0, 32'h0);
    overvolt_fault <= 1'h1;
    cnt(1'b1, 30, n);
    cmp_reg(n, 30 * TCK);
    wreg(4'h0, 32'h3);
    plugged <= 1'h1;
    wt(22);
    cnt(1'b1, 400, n);
    cmp_pin(n >= 20 * TCK - 2 && n <= 20 * TCK + 2,
            1'h1);
    n = 0;
    while (thermistor_pulldown_oe !== 1'h1 && n++ < 30 * TCK) @(posedge mclk);
    axi_rd(4'h8, rd, rs);
    cmp_reg(rd[6:5], 32'h3);
    overvolt_fault <= 1'h0;
    wt(1);
    cmp_pin(thermistor_pulldown_oe, 1'h0);
    plugged <= 1'h0;
    print_verdict();
  end
endmodule : tb

// ---- tb/tfl_charger_model.sv ----
// Purpose: charger sharing the thermistor and sense contacts with the pack
// Assumes: sense and thermistor contacts tied together inside the pack
// Notes: a grounded line hides the charger from both comparators
`timescale 1ns/1ps
module tfl_charger_model (
  // charger side
  input wire logic plugged,
  // pack side
  input wire logic pulldown_oe,
  output logic charger_sense,
  output logic sense_above_ext_bias
);
  assign sense_above_ext_bias = plugged && !pulldown_oe;
  assign charger_sense = plugged && !pulldown_oe;
endmodule : tfl_charger_model

// ---- tb/tfl_fault_asserts.sv ----
// Purpose: port-level checks of the thermistor and undervoltage fault logic
// Assumes: one mclk domain, nrst synchronous active low
// Notes: a temperature sample is located by the rising bias edge
`timescale 1ns/1ps
module tfl_fault_asserts #(
  parameter int TICK_CYC = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // watched signals
  input wire logic sense_above_ext_bias,
  input wire logic sense_below_hot,
  input wire logic sense_open_or_cold,
  input wire logic sense_shorted,
  input wire logic charger_sense,
  input wire logic charge_gate,
  input wire logic discharge_gate,
  input wire logic thermistor_bias_out,
  input wire logic thermistor_pulldown_oe,
  input wire logic regulator_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  int pd_cnt_q;
  // length of one unbroken pulldown stretch
  always_ff @(posedge mclk) begin
    if (!nrst || !thermistor_pulldown_oe) pd_cnt_q <= 0;
    else pd_cnt_q <= pd_cnt_q + 1;
  end
  property p_reg_off_gates;
    !regulator_en |-> !charge_gate && !discharge_gate;
  endproperty
  a_reg_off_gates: assert property (p_reg_off_gates)
    else $error("gate driven with regulator off");
  property p_ext_bias;
    sense_above_ext_bias [*8] |-> !thermistor_bias_out;
  endproperty
  a_ext_bias: assert property (p_ext_bias)
    else $error("bias pulsed with external supply present");
  property p_pd_release;
    pd_cnt_q <= 380 * TICK_CYC + 4;
  endproperty
  a_pd_release: assert property (p_pd_release)
    else $error("sense line held low past the frame");
  property p_shut_hold;
    (!charger_sense) [*6] ##0 !regulator_en |=> !regulator_en;
  endproperty
  a_shut_hold: assert property (p_shut_hold)
    else $error("left shutdown without charger");
  property p_hot;
    // sample flag was taken 3 cycles before the bias rises
    sense_below_hot [*8] ##0 $rose(thermistor_bias_out)
      |-> ##[0:6] (!charge_gate && regulator_en);
  endproperty
  a_hot: assert property (p_hot)
    else $error("hot sample left gates on or slept");
  property p_open;
    sense_open_or_cold [*8] ##0 $rose(thermistor_bias_out)
      |-> ##[0:6] (!charge_gate && regulator_en);
  endproperty
  a_open: assert property (p_open)
    else $error("open sample left gates on or slept");
  property p_short;
    sense_shorted [*8] ##0 $rose(thermistor_bias_out)
      |-> ##[0:6] !charge_gate;
  endproperty
  a_short: assert property (p_short)
    else $error("short sample left gates on");
  property p_wake;
    $rose(charger_sense) && !regulator_en && !thermistor_pulldown_oe
      |-> ##[1:8] regulator_en;
  endproperty
  a_wake: assert property (p_wake)
    else $error("charger did not wake the block");
  c_shut: cover property ($fell(regulator_en));
  c_pd: cover property ($rose(thermistor_pulldown_oe));
  c_gate_off: cover property ($fell(charge_gate));
endmodule : tfl_fault_asserts

bind tfl_fault_top tfl_fault_asserts #(.TICK_CYC(TICK_CYC)) chk_u (
  .mclk, .nrst, .sense_above_ext_bias, .sense_below_hot,
  .sense_open_or_cold, .sense_shorted, .charger_sense, .charge_gate,
  .discharge_gate,
  .thermistor_bias_out, .thermistor_pulldown_oe, .regulator_en
);
